// ---- common/mem_map_pkg.sv ----
/*
 * Address map constants and request carriers for the memory map decoder.
 * Assumes a 24-bit byte address space and a single system clock.
 */
`default_nettype none
package mem_map_pkg;
    localparam int ADDR_W         = 24;
    localparam int SEG_W          = 8;
    localparam int PAGE_W         = 2;
    localparam int FLASH_LINE_W   = 128;
    localparam logic [23:0] SEG_SIZE      = 24'h01_0000;
    localparam logic [23:0] PAGE_SIZE     = 24'h00_4000;
    localparam logic [23:0] DATA_RAM_LO      = 24'h00_A000;
    localparam logic [23:0] DATA_RAM_HI      = 24'h00_DFFF;
    localparam logic [23:0] XREG_LO       = 24'h00_E000;
    localparam logic [23:0] XREG_HI       = 24'h00_EFFF;
    localparam logic [23:0] EREG_LO       = 24'h00_F000;
    localparam logic [23:0] EREG_HI       = 24'h00_F1FF;
    localparam logic [23:0] DUAL_PORT_RAM_LO      = 24'h00_F600;
    localparam logic [23:0] DUAL_PORT_RAM_HI      = 24'h00_FDFF;
    localparam logic [23:0] DUAL_PORT_RAM_BIT_LO  = 24'h00_FD00;
    localparam logic [23:0] SREG_LO       = 24'h00_FE00;
    localparam logic [23:0] SREG_HI       = 24'h00_FFFF;
    localparam logic [23:0] EXTIO_LO      = 24'h21_0000;
    localparam logic [23:0] EXTIO_HI      = 24'h3F_FFFF;
    localparam logic [23:0] FLASH0_LO     = 24'hC0_0000;
    localparam logic [23:0] FLASH0_HI     = 24'hC3_FFFF;
    localparam logic [23:0] FLASH1_LO     = 24'hC4_0000;
    localparam logic [23:0] FLASH1_HI     = 24'hC4_FFFF;
    localparam logic [23:0] FLASH_RSV_LO  = 24'hC0_F000;
    localparam logic [23:0] FLASH_RSV_HI  = 24'hC0_FFFF;
    localparam logic [23:0] PRAM_LO       = 24'hE0_0000;
    localparam logic [23:0] PRAM_HI       = 24'hE7_FFFF;
    localparam logic [23:0] PRAM_MASK     = 24'h00_3FFF;
    localparam int SECTOR_SHIFT   = 12;
    localparam int CLUSTER_SHIFT  = 2;
    localparam int PROG_BLOCK_SHIFT = 7;
    localparam int GPR_COUNT      = 16;
    localparam int GPR_BYTE_COUNT = 8;

    typedef enum logic [3:0] {
        TGT_EXT    = 4'h0,
        TGT_DATA_RAM  = 4'h1,
        TGT_XREG   = 4'h2,
        TGT_EREG   = 4'h3,
        TGT_DUAL_PORT_RAM  = 4'h4,
        TGT_SREG   = 4'h5,
        TGT_FLASH0 = 4'h6,
        TGT_FLASH1 = 4'h7,
        TGT_FLASHR = 4'h8,
        TGT_PRAM   = 4'h9
    } target_t;

    typedef enum logic [1:0] {
        UNIT_IDLE = 2'h0,
        UNIT_PROG = 2'h1,
        UNIT_DATA = 2'h2,
        UNIT_SBUS = 2'h3
    } unit_t;

    typedef struct packed {
        logic              valid;
        logic              fetch;
        logic              write;
        logic              word;
        logic [23:0]       addr;
    } req_t;

    typedef struct packed {
        target_t           target;
        logic              ext_io;
        logic              bit_addr;
        logic [1:0]        page;
        logic [7:0]        segment;
        logic [23:0]       local_addr;
    } route_t;
endpackage
`default_nettype wire

// ---- src/mem_ecc_check.sv ----
/*
 * Soft-error check on one memory read word: parity or single-error correction.
 * Assumes the memory returns a six-bit Hamming check code and an even parity bit.
 */
`default_nettype none
module mem_ecc_check #(
    parameter int DATA_W = 16
) (
    input  wire logic [DATA_W-1:0] rd_data,
    input  wire logic [5:0]        rd_check,
    input  wire logic              rd_parity,
    input  wire logic              parity_en,
    input  wire logic              ecc_en,
    output logic      [DATA_W-1:0] out_data,
    output logic                   err_detect,
    output logic                   err_fixed
);
    function automatic logic [5:0] syndrome(input logic [DATA_W-1:0] d);
        logic [5:0] s;
        s = 6'h00;
        // Codes from 33 up are distinct and never one-hot, so a check bit flip is not fixed
        for (int i = 0; i < DATA_W; i++) begin
            s = s ^ 6'(i + 33);
        end
        for (int i = 0; i < DATA_W; i++) begin
            if (!d[i]) begin
                s = s ^ 6'(i + 33);
            end
        end
        return s;
    endfunction

    logic [5:0] syn;
    logic       par_bad;

    always_comb begin
        syn        = syndrome(rd_data) ^ rd_check;
        par_bad    = (^rd_data) ^ rd_parity;
        out_data   = rd_data;
        err_detect = 1'b0;
        err_fixed  = 1'b0;
        if (ecc_en && syn != 6'h00) begin
            err_detect = 1'b1;
            for (int i = 0; i < DATA_W; i++) begin
                if (syn == 6'(i + 33)) begin
                    out_data[i] = ~rd_data[i];
                    err_fixed   = 1'b1;
                end
            end
        end else if (!ecc_en && parity_en && par_bad) begin
            err_detect = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- src/memory_map_address_decoder.sv ----
/*
 * Address decoder and router for the 16-Mbyte linear space: picks one target,
 * steers fetches to the program access unit, internal segment 0 data to the data access unit and other data to the system bus.
 * Assumes one request per cycle from the core and synchronous memory answers.
 */
// Notes on behaviour
// - 256 segments of 64K, four 16K pages
// - Byte and word access everywhere
// - Internal memories and registers in segment 0
// - Dual port RAM F600 to FDFF
// - Top 256 bytes, general registers bit addressable
// - Sixteen word registers, low eight byte split
// - Two 512 byte register spaces decoded
// - Reserved areas go to external bus
// - External IO area disables pipeline optimisation
// - Program unit takes fetches, Flash, program RAM
// - Data unit takes data, data RAM, peripherals
// - System bus links units both ways
// - Program RAM mirrored, protectable region
// - Flash 4K sectors, 128 byte blocks
// - Top segment 0 Flash sector reserved
// - 128 bit Flash reads, modules parallel
// - Flash read protection unlocked by password
// - Protection per sector cluster
// - Parity errors block faulty data
// - ECC corrects single data bit errors
`default_nettype none
module memory_map_address_decoder #(
    parameter int          DATA_W   = 16,
    parameter logic [31:0] PASSWORD = 32'hA5A5_5A5A
) (
    input  wire logic                        clk_sys,
    input  wire logic                        srst,
    input  wire mem_map_pkg::req_t           req,
    input  wire logic [DATA_W-1:0]           wdata,
    input  wire logic [1:0]                  byte_en,
    input  wire logic                        ext_bus_present,
    input  wire logic [13:0]                 pram_prot_limit,
    input  wire logic [31:0]                 flash_wprot_clusters,
    input  wire logic                        flash_rprot,
    input  wire logic                        pw_valid,
    input  wire logic [31:0]                 pw_word,
    input  wire logic                        relock,
    input  wire logic [DATA_W-1:0]           mem_rdata,
    input  wire logic [5:0]                  mem_rcheck,
    input  wire logic                        mem_rparity,
    input  wire logic                        parity_en,
    input  wire logic                        ecc_en,
    input  wire logic                        flash0_busy,
    input  wire logic                        flash1_busy,
    output mem_map_pkg::route_t              route,
    output mem_map_pkg::unit_t               unit_sel,
    output logic                             sysbus_xfer,
    output logic                             pipe_opt_off,
    output logic                             access_ok,
    output logic                             access_blocked,
    output logic [1:0]                       lane_en,
    output logic [DATA_W-1:0]                lane_wdata,
    output logic [8:0]                       flash_line,
    output logic [4:0]                       flash_sector,
    output logic [9:0]                       flash_block,
    output logic [3:0]                       gpr_index,
    output logic                             flash_unlocked,
    output logic [DATA_W-1:0]                rdata,
    output logic                             rd_error,
    output logic                             rd_corrected
);
    typedef enum logic [1:0] {
        LOCK_IDLE  = 2'b00,
        LOCK_HALF  = 2'b01,
        LOCK_OPEN  = 2'b10
    } lock_t;

    function automatic logic in_range(input logic [23:0] a, lo, hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic mem_map_pkg::target_t decode(input logic [23:0] a);
        if (a[23:16] == 8'h00 && in_range(a, mem_map_pkg::DATA_RAM_LO, mem_map_pkg::DATA_RAM_HI)) begin
            return mem_map_pkg::TGT_DATA_RAM;
        end else if (in_range(a, mem_map_pkg::XREG_LO, mem_map_pkg::XREG_HI)) begin
            return mem_map_pkg::TGT_XREG;
        end else if (in_range(a, mem_map_pkg::EREG_LO, mem_map_pkg::EREG_HI)) begin
            return mem_map_pkg::TGT_EREG;
        end else if (in_range(a, mem_map_pkg::DUAL_PORT_RAM_LO, mem_map_pkg::DUAL_PORT_RAM_HI)) begin
            return mem_map_pkg::TGT_DUAL_PORT_RAM;
        end else if (in_range(a, mem_map_pkg::SREG_LO, mem_map_pkg::SREG_HI)) begin
            return mem_map_pkg::TGT_SREG;
        end else if (in_range(a, mem_map_pkg::FLASH_RSV_LO, mem_map_pkg::FLASH_RSV_HI)) begin
            return mem_map_pkg::TGT_FLASHR;
        end else if (in_range(a, mem_map_pkg::FLASH0_LO, mem_map_pkg::FLASH0_HI)) begin
            return mem_map_pkg::TGT_FLASH0;
        end else if (in_range(a, mem_map_pkg::FLASH1_LO, mem_map_pkg::FLASH1_HI)) begin
            return mem_map_pkg::TGT_FLASH1;
        end else if (in_range(a, mem_map_pkg::PRAM_LO, mem_map_pkg::PRAM_HI)) begin
            return mem_map_pkg::TGT_PRAM;
        end else begin
            return mem_map_pkg::TGT_EXT;
        end
    endfunction

    function automatic logic is_prog_target(input mem_map_pkg::target_t t);
        return t == mem_map_pkg::TGT_FLASH0 || t == mem_map_pkg::TGT_FLASH1
            || t == mem_map_pkg::TGT_FLASHR || t == mem_map_pkg::TGT_PRAM;
    endfunction

    mem_map_pkg::target_t tgt;
    mem_map_pkg::route_t  next_route;
    mem_map_pkg::unit_t   next_unit;
    logic                 next_sysbus;
    logic                 next_pipe_off;
    logic                 next_ok;
    logic                 next_blocked;
    logic [1:0]           next_lane_en;
    logic [DATA_W-1:0]    next_lane_wdata;
    logic [8:0]           next_flash_line;
    logic [4:0]           next_flash_sector;
    logic [9:0]           next_flash_block;
    logic [3:0]           next_gpr_index;
    logic                 wprot_hit;
    logic                 rprot_hit;
    logic [4:0]           sector_num;
    logic                 flash_busy_hit;
    lock_t                lock_state;
    lock_t                next_lock_state;
    logic [DATA_W-1:0]    chk_data;
    logic                 chk_err;
    logic                 chk_fixed;
    logic                 rd_pending;
    logic                 next_rd_pending;
    logic [DATA_W-1:0]    next_rdata;
    logic                 next_rd_error;
    logic                 next_rd_corrected;

    mem_ecc_check #(
        .DATA_W (DATA_W)
    ) u_ecc (
        .rd_data    (mem_rdata),
        .rd_check   (mem_rcheck),
        .rd_parity  (mem_rparity),
        .parity_en  (parity_en),
        .ecc_en     (ecc_en),
        .out_data   (chk_data),
        .err_detect (chk_err),
        .err_fixed  (chk_fixed)
    );

    always_comb begin
        tgt = decode(req.addr);
        if (tgt == mem_map_pkg::TGT_EXT && !ext_bus_present) begin
            tgt = mem_map_pkg::TGT_EXT;
        end
        sector_num     = 5'(req.addr[17:mem_map_pkg::SECTOR_SHIFT]);
        // Protection bits per cluster of four sectors keeps the control word small
        wprot_hit      = req.write && (tgt == mem_map_pkg::TGT_FLASH0
                         || tgt == mem_map_pkg::TGT_FLASH1)
                         && flash_wprot_clusters[sector_num >> mem_map_pkg::CLUSTER_SHIFT];
        rprot_hit      = !req.write && flash_rprot && lock_state != LOCK_OPEN
                         && !req.fetch && (tgt == mem_map_pkg::TGT_FLASH0
                         || tgt == mem_map_pkg::TGT_FLASH1);
        flash_busy_hit = (tgt == mem_map_pkg::TGT_FLASH0 && flash0_busy)
                         || (tgt == mem_map_pkg::TGT_FLASH1 && flash1_busy);
        next_route.target     = tgt;
        next_route.segment    = req.addr[23:16];
        next_route.page       = req.addr[15:14];
        next_route.ext_io     = in_range(req.addr, mem_map_pkg::EXTIO_LO, mem_map_pkg::EXTIO_HI);
        next_route.bit_addr   = (tgt == mem_map_pkg::TGT_DUAL_PORT_RAM && req.addr >= mem_map_pkg::DUAL_PORT_RAM_BIT_LO)
                                || tgt == mem_map_pkg::TGT_SREG || tgt == mem_map_pkg::TGT_EREG;
        next_route.local_addr = (tgt == mem_map_pkg::TGT_PRAM) ? (req.addr & mem_map_pkg::PRAM_MASK)
                                                              : req.addr;
        next_pipe_off  = req.valid && next_route.ext_io;
        if (!req.valid) begin
            next_unit = mem_map_pkg::UNIT_IDLE;
        end else if (req.fetch) begin
            next_unit = mem_map_pkg::UNIT_PROG;
        end else if (is_prog_target(tgt) || tgt == mem_map_pkg::TGT_EXT) begin
            next_unit = mem_map_pkg::UNIT_SBUS;
        end else begin
            next_unit = mem_map_pkg::UNIT_DATA;
        end
        next_sysbus    = next_unit == mem_map_pkg::UNIT_SBUS
                         || (req.valid && req.fetch && tgt == mem_map_pkg::TGT_EXT);
        next_blocked   = req.valid && (wprot_hit || rprot_hit || flash_busy_hit
                         || (req.write && tgt == mem_map_pkg::TGT_FLASHR)
                         || (req.write && tgt == mem_map_pkg::TGT_PRAM
                             && next_route.local_addr[13:0] < pram_prot_limit));
        next_ok        = req.valid && !next_blocked;
        // Word access uses both lanes; byte access picks the lane from addr[0]
        if (req.word) begin
            next_lane_en    = 2'b11;
            next_lane_wdata = wdata;
        end else begin
            next_lane_en    = req.addr[0] ? 2'b10 : 2'b01;
            next_lane_wdata = {wdata[7:0], wdata[7:0]};
        end
        next_lane_en      = next_lane_en & (req.word ? 2'b11 : (byte_en | next_lane_en));
        next_flash_line   = 9'(req.addr[12:4]);
        next_flash_sector = sector_num;
        next_flash_block  = 10'(req.addr[16:mem_map_pkg::PROG_BLOCK_SHIFT]);
        next_gpr_index    = req.word ? 4'(req.addr[4:1]) : {1'b0, req.addr[3:1]};
    end

    always_comb begin
        next_lock_state = lock_state;
        case (lock_state)
            LOCK_IDLE: begin
                if (pw_valid && pw_word == PASSWORD) begin
                    next_lock_state = LOCK_HALF;
                end
            end
            LOCK_HALF: begin
                if (pw_valid) begin
                    next_lock_state = (pw_word == ~PASSWORD) ? LOCK_OPEN : LOCK_IDLE;
                end
            end
            LOCK_OPEN: begin
                if (relock) begin
                    next_lock_state = LOCK_IDLE;
                end
            end
            default: begin
                next_lock_state = LOCK_IDLE;
            end
        endcase
    end

    always_comb begin
        next_rd_pending   = req.valid && !req.write && next_ok;
        next_rdata        = rdata;
        next_rd_error     = 1'b0;
        next_rd_corrected = 1'b0;
        if (rd_pending) begin
            next_rd_error     = chk_err && !chk_fixed;
            next_rd_corrected = chk_fixed;
            next_rdata        = (chk_err && !chk_fixed) ? '0 : chk_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            route          <= '0;
            unit_sel       <= mem_map_pkg::UNIT_IDLE;
            sysbus_xfer    <= 1'b0;
            pipe_opt_off   <= 1'b0;
            access_ok      <= 1'b0;
            access_blocked <= 1'b0;
            lane_en        <= 2'b00;
            lane_wdata     <= '0;
            flash_line     <= 9'h000;
            flash_sector   <= 5'h00;
            flash_block    <= 10'h000;
            gpr_index      <= 4'h0;
            lock_state     <= LOCK_IDLE;
            rd_pending     <= 1'b0;
            rdata          <= '0;
            rd_error       <= 1'b0;
            rd_corrected   <= 1'b0;
        end else begin
            route          <= next_route;
            unit_sel       <= next_unit;
            sysbus_xfer    <= next_sysbus;
            pipe_opt_off   <= next_pipe_off;
            access_ok      <= next_ok;
            access_blocked <= next_blocked;
            lane_en        <= next_ok ? next_lane_en : 2'b00;
            lane_wdata     <= next_lane_wdata;
            flash_line     <= next_flash_line;
            flash_sector   <= next_flash_sector;
            flash_block    <= next_flash_block;
            gpr_index      <= next_gpr_index;
            lock_state     <= next_lock_state;
            rd_pending     <= next_rd_pending;
            rdata          <= next_rdata;
            rd_error       <= next_rd_error;
            rd_corrected   <= next_rd_corrected;
        end
    end

    assign flash_unlocked = (lock_state == LOCK_OPEN);

    sfr_decode_a: assert property (@(posedge clk_sys) disable iff (srst)
        req.valid && req.addr >= mem_map_pkg::SREG_LO && req.addr <= mem_map_pkg::SREG_HI
        |=> route.target == mem_map_pkg::TGT_SREG)
        else $error("special register area misdecoded");
    dual_port_ram_decode_a: assert property (@(posedge clk_sys) disable iff (srst)
        req.valid && req.addr >= mem_map_pkg::DUAL_PORT_RAM_LO && req.addr <= mem_map_pkg::DUAL_PORT_RAM_HI
        |=> route.target == mem_map_pkg::TGT_DUAL_PORT_RAM)
        else $error("dual port area misdecoded");
    ext_io_a: assert property (@(posedge clk_sys) disable iff (srst)
        req.valid && req.addr >= mem_map_pkg::EXTIO_LO && req.addr <= mem_map_pkg::EXTIO_HI
        |=> pipe_opt_off && route.target == mem_map_pkg::TGT_EXT)
        else $error("external io not flagged");
    fetch_unit_a: assert property (@(posedge clk_sys) disable iff (srst)
        req.valid && req.fetch |=> unit_sel == mem_map_pkg::UNIT_PROG)
        else $error("fetch not on program unit");
    data_unit_a: assert property (@(posedge clk_sys) disable iff (srst)
        req.valid && !req.fetch && req.addr >= mem_map_pkg::DATA_RAM_LO
        && req.addr <= mem_map_pkg::DATA_RAM_HI |=> unit_sel == mem_map_pkg::UNIT_DATA)
        else $error("data ram not on data unit");
    pram_mirror_a: assert property (@(posedge clk_sys) disable iff (srst)
        req.valid && req.addr >= mem_map_pkg::PRAM_LO && req.addr <= mem_map_pkg::PRAM_HI
        |=> route.local_addr[23:14] == 10'h000)
        else $error("program ram mirror wrong");
    rsv_sector_a: assert property (@(posedge clk_sys) disable iff (srst)
        req.valid && req.write && req.addr >= mem_map_pkg::FLASH_RSV_LO
        && req.addr <= mem_map_pkg::FLASH_RSV_HI |=> access_blocked)
        else $error("reserved sector written");
    unlock_seq_a: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(flash_unlocked) |-> $past(pw_valid) && $past(pw_word) == ~PASSWORD)
        else $error("unlock without password");
    parity_block_a: assert property (@(posedge clk_sys) disable iff (srst)
        rd_error |-> rdata == '0)
        else $error("faulty read data passed");
    byte_lane_a: assert property (@(posedge clk_sys) disable iff (srst)
        access_ok && !$past(req.word) |-> $onehot(lane_en))
        else $error("byte access lanes wrong");

    ext_cov: cover property (@(posedge clk_sys) access_ok && route.target == mem_map_pkg::TGT_EXT);
    unlock_cov: cover property (@(posedge clk_sys) $rose(flash_unlocked));
    fix_cov: cover property (@(posedge clk_sys) rd_corrected);
endmodule
`default_nettype wire

// ---- test/mem_partner.sv ----
/* Memory partner model: read data of the selected memory.
   Assumes the bench holds each read request steady while it waits. */
`default_nettype none
module mem_partner (
    input  wire logic              clk_sys,
    input  wire mem_map_pkg::req_t req,
    input  wire logic              flip,
    output logic [15:0]            mem_rdata,
    output logic [5:0]             mem_rcheck,
    output logic                   mem_rparity
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] data;
    // Idle cycles invert the data each cycle, so a stale word shows again on every second idle cycle
    always_ff @(posedge clk_sys) begin
        data <= req.valid ? (req.addr[15:0] ^ 16'h5A3C) : ~data;
    end
    assign mem_rdata   = data ^ {15'h0000, flip};
    assign mem_rparity = ^data;
    always_comb begin
        mem_rcheck = 6'h00;
        for (int i = 0; i < 16; i++) begin
            if (data[i]) begin
                mem_rcheck = mem_rcheck ^ 6'(i + 33);
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/memory_map_address_decoder_test.sv ----
/* Self-checking bench for the address decoder.
   Assumes fixed one-cycle route latency and a memory answer per request. */
`default_nettype none
module memory_map_address_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, srst = 1, rprot = 0, pw_valid = 0, relock = 0;
    logic par = 1, f1busy = 0, flip = 0, ecc = 0, fixd;
    logic [31:0] pw_word = 32'h0000_0000, wprot = 32'h0000_0000;
    logic [13:0] plim = 14'h0000;
    mem_map_pkg::req_t req = '0;
    mem_map_pkg::route_t route;
    mem_map_pkg::unit_t unit_sel;
    logic [15:0] mem_rdata, rdata;
    logic [5:0] mem_rcheck;
    logic mem_rparity, sysbus, pipe_off, ok, blk, unl, rderr;
    logic [1:0] lane;
    logic [23:0] a;
    int fails = 0, compares = 0;
    always #2 clk_sys = ~clk_sys;
    memory_map_address_decoder uut (.clk_sys(clk_sys), .srst(srst), .req(req),
        .wdata(16'h1234), .byte_en(2'h3), .ext_bus_present(1'b1), .pram_prot_limit(plim),
        .flash_wprot_clusters(wprot), .flash_rprot(rprot), .pw_valid(pw_valid),
        .pw_word(pw_word), .relock(relock), .mem_rdata(mem_rdata), .mem_rcheck(mem_rcheck),
        .mem_rparity(mem_rparity), .parity_en(par), .ecc_en(ecc), .flash0_busy(1'b0),
        .flash1_busy(f1busy), .route(route), .unit_sel(unit_sel), .sysbus_xfer(sysbus),
        .pipe_opt_off(pipe_off), .access_ok(ok), .access_blocked(blk), .lane_en(lane),
        .lane_wdata(), .flash_line(), .flash_sector(), .flash_block(), .gpr_index(),
        .flash_unlocked(unl), .rdata(rdata), .rd_error(rderr), .rd_corrected(fixd));
    mem_partner partner (.clk_sys(clk_sys), .req(req), .flip(flip), .mem_rdata(mem_rdata),
        .mem_rcheck(mem_rcheck), .mem_rparity(mem_rparity));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Request is held n cycles so registered answers are steady when sampled
    task automatic acc(logic [23:0] ad, logic f, logic w, logic wd, int n);
        req = '{1'b1, f, w, wd, ad};
        repeat (n) @(negedge clk_sys);
    endtask
    function automatic logic [3:0] tgt(logic [23:0] x);
        if (x >= 24'h00A000 && x <= 24'h00DFFF) return 4'h1;
        if (x >= 24'h00E000 && x <= 24'h00EFFF) return 4'h2;
        if (x >= 24'h00F000 && x <= 24'h00F1FF) return 4'h3;
        if (x >= 24'h00F600 && x <= 24'h00FDFF) return 4'h4;
        if (x >= 24'h00FE00 && x <= 24'h00FFFF) return 4'h5;
        if (x >= 24'hC0F000 && x <= 24'hC0FFFF) return 4'h8;
        if (x >= 24'hC00000 && x <= 24'hC3FFFF) return 4'h6;
        if (x >= 24'hC40000 && x <= 24'hC4FFFF) return 4'h7;
        if (x >= 24'hE00000 && x <= 24'hE7FFFF) return 4'h9;
        return 4'h0;
    endfunction
    function automatic logic io(logic [23:0] x);
        return x >= 24'h210000 && x <= 24'h3FFFFF;
    endfunction
    initial begin
        #400000;
        fails++;
        end_of_test();
    end
    initial begin
        void'($urandom(64));
        repeat (12) @(negedge clk_sys);
        check("target at reset", route.target, 4'h0);
        srst = 0;
        for (int i = 0; i < 300; i++) begin
            a = i < 12 ? 24'({24'h00A000, 24'h00DFFF, 24'h00F1FF, 24'h00F200, 24'h00F600,
                24'h00FFFF, 24'hC0F000, 24'hC4FFFF, 24'hE7FFFF, 24'h210000, 24'h3FFFFF,
                24'hFFFF00} >> (24 * (11 - i))) : 24'($urandom);
            acc(a, 1'b0, 1'b0, 1'b1, 1); // Reads only
            check("target", route.target, tgt(a));
            check("segment", route.segment, a[23:16]);
            check("page", route.page, a[15:14]);
            check("pipe off", pipe_off, io(a));
            check("read ok", ok, 1'b1);
        end
        $display("test decode done");
        for (int i = 0; i < 3; i++) begin
            acc(24'h00A000 + 24'(i[0]), 1'b0, 1'b1, i[1], 1);
            check("lanes", lane, i[1] ? 2'h3 : (i[0] ? 2'h2 : 2'h1));
        end
        acc(24'hE00010, 1'b1, 1'b0, 1'b1, 1);
        check("fetch unit", unit_sel, mem_map_pkg::UNIT_PROG);
        acc(24'h00A010, 1'b0, 1'b0, 1'b1, 1);
        check("data unit", unit_sel, mem_map_pkg::UNIT_DATA);
        check("no sysbus", sysbus, 1'b0);
        acc(24'hC00010, 1'b0, 1'b0, 1'b1, 1);
        check("operand via sysbus", sysbus, 1'b1);
        $display("test units done");
        plim = 14'h0100;
        wprot = 32'h0000_0002;
        acc(24'hE40080, 1'b0, 1'b1, 1'b1, 1);
        check("pram mirror protected", blk, 1'b1);
        check("no lanes", lane, 2'h0);
        acc(24'hE00200, 1'b0, 1'b1, 1'b1, 1);
        check("pram writable", ok, 1'b1);
        acc(24'hC04000, 1'b0, 1'b1, 1'b1, 1);
        check("cluster protected", blk, 1'b1);
        acc(24'hC07FFE, 1'b0, 1'b1, 1'b1, 1);
        check("cluster last sector", blk, 1'b1);
        acc(24'hC03000, 1'b0, 1'b1, 1'b1, 1);
        check("sector free", ok, 1'b1);
        acc(24'hC0F000, 1'b0, 1'b1, 1'b1, 1);
        check("reserved sector", blk, 1'b1);
        f1busy = 1;
        acc(24'hC40000, 1'b0, 1'b0, 1'b1, 1);
        check("busy module", blk, 1'b1);
        acc(24'hC00000, 1'b0, 1'b0, 1'b1, 1);
        check("other module", ok, 1'b1);
        f1busy = 0;
        $display("test protect done");
        rprot = 1;
        acc(24'hC00020, 1'b0, 1'b0, 1'b1, 1);
        check("locked read", blk, 1'b1);
        acc(24'hC00020, 1'b1, 1'b0, 1'b1, 1);
        check("fetch allowed", ok, 1'b1);
        pw_valid = 1;
        pw_word = 32'hA5A5_5A5A;
        @(negedge clk_sys);
        pw_word = ~pw_word;
        @(negedge clk_sys);
        pw_valid = 0;
        acc(24'hC00020, 1'b0, 1'b0, 1'b1, 2);
        check("unlocked", unl, 1'b1);
        check("read after unlock", ok, 1'b1);
        relock = 1;
        @(negedge clk_sys);
        relock = 0;
        acc(24'hC00020, 1'b0, 1'b0, 1'b1, 2);
        check("relocked", blk, 1'b1);
        $display("test password done");
        for (int i = 0; i < 6; i++) begin
            a = {8'h00, 2'b10, 14'($urandom)};
            flip = i[0];
            par = i[1];
            ecc = i[2];
            acc(a, 1'b0, 1'b0, 1'b1, 4);
            check("parity flag", rderr, i == 3);
            check("corrected", fixd, i == 5);
            check("rdata", rdata, i == 3 ? 16'h0000 : (a[15:0] ^ 16'h5A3C ^ 16'(i == 1)));
        end
        $display("test parity done");
        end_of_test();
    end
endmodule
`default_nettype wire
